// [pkg/bat_pkg.sv]
// constants for the window address translation block
package bat_pkg;
   // ****************************************
   // sizes
   // ****************************************
   localparam int NUM_WIN     = 6;
   localparam int ADDR_W      = 64;
   localparam int HALF_W      = 32;
   localparam int PART_W      = 3;
   localparam int WIN_W       = 3;
   localparam int SETUP_W     = 32;
   localparam int SIZE_W      = 6;
   localparam int LUT_ENTRIES = 24;
   localparam int LUT_IDX_W   = 5;
   // ****************************************
   // setup register field layout
   // ****************************************
   localparam int SU_IO     = 0;
   localparam int SU_PAIR   = 1;
   localparam int SU_SIZE_L = 2;
   localparam int SU_LOOKUP = 8;
   localparam int SU_PART_L = 9;
   localparam int SU_EN     = 12;
   localparam int SU_CFG    = 13;
   localparam int SU_LUT24  = 14;
   localparam logic [SIZE_W-1:0] SIZE_1MB = 6'h14;
   // ****************************************
   // window numbers and lookup table split
   // ****************************************
   localparam logic [WIN_W-1:0]     WIN_CFG   = 3'h0;
   localparam logic [WIN_W-1:0]     WIN_LUT_A = 3'h2;
   localparam logic [WIN_W-1:0]     WIN_LUT_B = 3'h4;
   localparam logic [LUT_IDX_W-1:0] LUT_SMALL = 5'h0C;
   localparam logic [LUT_IDX_W-1:0] LUT_LARGE = 5'h18;
   localparam logic [SIZE_W-1:0]    IDX_SMALL_W = 6'h04;
   localparam logic [SIZE_W-1:0]    IDX_LARGE_W = 6'h05;
endpackage

// [rtl/bat_win_match.sv]
// one base address window compare
`timescale 1ns/100ps
`default_nettype none
module bat_win_match (
   // window settings
   input  wire logic [bat_pkg::ADDR_W-1:0] winBase,
   input  wire logic [bat_pkg::SIZE_W-1:0] sizeExp,
   input  wire logic                       winIo,
   input  wire logic                       winEn,
   // request
   input  wire logic [bat_pkg::ADDR_W-1:0] reqAddr,
   input  wire logic                       reqIo,
   // result
   output logic                            hit,
   output logic      [bat_pkg::ADDR_W-1:0] offMask
);
   import bat_pkg::*;
   wire logic [ADDR_W-1:0] diff;
   assign offMask = (64'h1 << sizeExp) - 64'h1;
   assign diff    = (reqAddr ^ winBase) & ~offMask;
   assign hit     = winEn && (winIo == reqIo) && (diff == 64'h0);
endmodule
`default_nettype wire

// [rtl/bat_lut.sv]
// translation lookup table, flip-flop storage
`timescale 1ns/100ps
`default_nettype none
module bat_lut #(
   parameter int ENTRIES = bat_pkg::LUT_ENTRIES
) (
   // clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          resetn,
   // write port
   input  wire logic                          wrEn,
   input  wire logic [bat_pkg::LUT_IDX_W-1:0] wrIdx,
   input  wire logic                          wrValid,
   input  wire logic [bat_pkg::PART_W-1:0]    wrPart,
   input  wire logic [bat_pkg::ADDR_W-1:0]    wrAddr,
   // read port
   input  wire logic [bat_pkg::LUT_IDX_W-1:0] rdIdx,
   output logic                               rdValid,
   output logic      [bat_pkg::PART_W-1:0]    rdPart,
   output logic      [bat_pkg::ADDR_W-1:0]    rdAddr
);
   import bat_pkg::*;
   logic [ENTRIES-1:0]             valid_r;
   logic [ENTRIES-1:0][PART_W-1:0] part_r;
   logic [ENTRIES-1:0][ADDR_W-1:0] addr_r;

   for (genvar e = 0; e < ENTRIES; e++) begin : g_ent
      wire logic sel = wrEn && (wrIdx == LUT_IDX_W'(e));
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            valid_r[e] <= 1'b0;
            part_r[e]  <= '0;
            addr_r[e]  <= '0;
         end else if (sel) begin
            valid_r[e] <= wrValid;
            part_r[e]  <= wrPart;
            addr_r[e]  <= wrAddr;
         end
      end
   end

   // out-of-range index reads as an invalid entry
   wire logic inRange = rdIdx < LUT_IDX_W'(ENTRIES);
   assign rdValid = inRange && valid_r[rdIdx];
   assign rdPart  = inRange ? part_r[rdIdx] : '0;
   assign rdAddr  = inRange ? addr_r[rdIdx] : '0;
endmodule
`default_nettype wire

// [rtl/bat_bar_translation.sv]
// inbound window match and address translation for a bridge function
`timescale 1ns/100ps
`default_nettype none
module bat_bar_translation #(
   parameter int NUM_WIN = bat_pkg::NUM_WIN,
   parameter int LUT_N   = bat_pkg::LUT_ENTRIES
) (
   // clock and reset
   input  wire logic                                      sys_clk,
   input  wire logic                                      resetn,
   // received request
   input  wire logic                                      tlpValid,
   input  wire logic [bat_pkg::ADDR_W-1:0]                tlpAddr,
   input  wire logic                                      tlpIo,
   // window configuration
   input  wire logic [NUM_WIN-1:0][bat_pkg::HALF_W-1:0]   barBase,
   input  wire logic [NUM_WIN-1:0][bat_pkg::SETUP_W-1:0]  window_setup_reg,
   input  wire logic [NUM_WIN-1:0][bat_pkg::HALF_W-1:0]   window_lower_translated_base,
   input  wire logic [NUM_WIN-1:0][bat_pkg::HALF_W-1:0]   window_upper_translated_base,
   // lookup table write port
   input  wire logic                                      lutWrEn,
   input  wire logic [bat_pkg::LUT_IDX_W-1:0]             lutWrIdx,
   input  wire logic                                      lutWrValid,
   input  wire logic [bat_pkg::PART_W-1:0]                lutWrPart,
   input  wire logic [bat_pkg::ADDR_W-1:0]                lutWrAddr,
   // forwarded request
   output logic                                           fwdValid_r,
   output logic      [bat_pkg::ADDR_W-1:0]                fwdAddr_r,
   output logic                                           fwdAddr64_r,
   output logic      [bat_pkg::PART_W-1:0]                fwdPart_r,
   output logic      [bat_pkg::WIN_W-1:0]                 fwdWin_r,
   output logic                                           fwdIo_r,
   // local config access and drop
   output logic                                           cfgValid_r,
   output logic                                           dropValid_r
);
   import bat_pkg::*;

   // ****************************************
   // per-window compare
   // ****************************************
   logic [NUM_WIN-1:0]             winHit;
   logic [NUM_WIN-1:0][ADDR_W-1:0] winMask;
   logic [NUM_WIN-1:0][ADDR_W-1:0] winTb;

   for (genvar w = 0; w < NUM_WIN; w++) begin : g_win
      localparam int NX = (w + 1 < NUM_WIN) ? w + 1 : w;
      localparam int PV = (w > 0) ? w - 1 : 0;
      wire logic [SETUP_W-1:0] su = window_setup_reg[w];
      wire logic pairLo = (w % 2 == 0) && (w + 1 < NUM_WIN) && su[SU_PAIR];
      wire logic pairHi = (w % 2 == 1) && window_setup_reg[PV][SU_PAIR];
      wire logic [ADDR_W-1:0] base =
         {pairLo ? barBase[NX] : 32'h0, barBase[w]};
      // translated base from lower and upper halves
      assign winTb[w] = {window_upper_translated_base[w],
                         window_lower_translated_base[w]};
      // masked upper bits decide the hit
      bat_win_match u_match (
         .winBase (base),
         .sizeExp (su[SU_SIZE_L +: SIZE_W]),
         .winIo   (su[SU_IO]),
         .winEn   (su[SU_EN] && !pairHi),
         .reqAddr (tlpAddr),
         .reqIo   (tlpIo),
         .hit     (winHit[w]),
         .offMask (winMask[w])
      );
   end

   // ****************************************
   // window select
   // ****************************************
   // lowest numbered hit wins
   logic [WIN_W-1:0] hitIdx;
   always_comb begin
      hitIdx = '0;
      for (int i = NUM_WIN - 1; i >= 0; i--) begin
         if (winHit[i]) begin
            hitIdx = WIN_W'(i);
         end
      end
   end

   wire logic               anyHit  = |winHit;
   wire logic [SETUP_W-1:0] selSu   = window_setup_reg[hitIdx];
   wire logic [ADDR_W-1:0]  selMask = winMask[hitIdx];
   wire logic [ADDR_W-1:0]  selTb   = winTb[hitIdx];
   wire logic [SIZE_W-1:0]  selSize = selSu[SU_SIZE_L +: SIZE_W];
   wire logic [PART_W-1:0]  selPart = selSu[SU_PART_L +: PART_W];

   // ****************************************
   // lookup table split
   // ****************************************
   // table select honoured on windows two and four only
   wire logic lutWin  = (hitIdx == WIN_LUT_A) || (hitIdx == WIN_LUT_B);
   wire logic lutMode = lutWin && selSu[SU_LOOKUP];
   // both table windows active limits window two
   wire logic bothLut = window_setup_reg[WIN_LUT_A][SU_LOOKUP]
                     && window_setup_reg[WIN_LUT_B][SU_LOOKUP];
   // large table only for window two
   wire logic use24 = (hitIdx == WIN_LUT_A)
                   && window_setup_reg[WIN_LUT_A][SU_LUT24] && !bothLut;
   wire logic [SIZE_W-1:0]    idxW   = use24 ? IDX_LARGE_W : IDX_SMALL_W;
   wire logic [LUT_IDX_W-1:0] idxCnt = use24 ? LUT_LARGE : LUT_SMALL;
   // sub-window offset below the index bits
   // 16 MB window, 4 index bits, 1 MB per entry
   wire logic [SIZE_W-1:0]    subExp   = selSize - idxW;
   wire logic [ADDR_W-1:0]    subMask  = (64'h1 << subExp) - 64'h1;
   wire logic [ADDR_W-1:0]    idxShift = tlpAddr >> subExp;
   wire logic [LUT_IDX_W-1:0] rawIdx   =
      use24 ? idxShift[LUT_IDX_W-1:0] : {1'b0, idxShift[LUT_IDX_W-2:0]};
   // unused upper index codes of a 12-entry table never reach an entry
   wire logic                 idxOk  = rawIdx < idxCnt;
   // window four owns the upper half of the table
   wire logic [LUT_IDX_W-1:0] lutIdx =
      (hitIdx == WIN_LUT_B) ? rawIdx + LUT_SMALL : rawIdx;

   logic                  lutRdValid;
   logic [PART_W-1:0]     lutRdPart;
   logic [ADDR_W-1:0]     lutRdAddr;

   // entry holds valid, partition and translated base
   bat_lut #(
      .ENTRIES (LUT_N)
   ) u_lut (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .wrEn    (lutWrEn),
      .wrIdx   (lutWrIdx),
      .wrValid (lutWrValid),
      .wrPart  (lutWrPart),
      .wrAddr  (lutWrAddr),
      .rdIdx   (lutIdx),
      .rdValid (lutRdValid),
      .rdPart  (lutRdPart),
      .rdAddr  (lutRdAddr)
   );

   // ****************************************
   // translation and routing
   // ****************************************
   // direct: translated base over the window offset
   wire logic [ADDR_W-1:0] dirAddr = (selTb & ~selMask) | (tlpAddr & selMask);
   // table: entry base replaces base and index bits
   wire logic [ADDR_W-1:0] lutAddr =
      (lutRdAddr & ~subMask) | (tlpAddr & subMask);
   wire logic lutOk = idxOk && lutRdValid;
   // window zero may target local registers
   wire logic cfgHit = anyHit && (hitIdx == WIN_CFG) && selSu[SU_CFG];
   wire logic fwdNow = tlpValid && anyHit && !cfgHit && (!lutMode || lutOk);
   // miss or unusable entry is dropped
   wire logic dropNow = tlpValid && !fwdNow && !cfgHit;
   wire logic [ADDR_W-1:0] addrNxt =
      cfgHit ? (tlpAddr & selMask) : (lutMode ? lutAddr : dirAddr);
   wire logic [PART_W-1:0] partNxt = lutMode ? lutRdPart : selPart;
   // output width follows the translated upper half
   wire logic wideNxt = addrNxt[ADDR_W-1:HALF_W] != 32'h0;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fwdValid_r  <= 1'b0;
         cfgValid_r  <= 1'b0;
         dropValid_r <= 1'b0;
      end else begin
         fwdValid_r  <= fwdNow;
         cfgValid_r  <= tlpValid && cfgHit;
         dropValid_r <= dropNow;
      end
   end

   // payload fields only mean something beside a valid flag
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fwdAddr_r   <= '0;
         fwdAddr64_r <= 1'b0;
         fwdPart_r   <= '0;
         fwdWin_r    <= '0;
         fwdIo_r     <= 1'b0;
      end else if (tlpValid) begin
         fwdAddr_r   <= addrNxt;
         fwdAddr64_r <= wideNxt;
         fwdPart_r   <= partNxt;
         fwdWin_r    <= hitIdx;
         fwdIo_r     <= tlpIo;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   logic [ADDR_W-1:0]    chkMask_r;
   logic [ADDR_W-1:0]    chkAddr_r;
   logic                 chkLut_r;
   logic [LUT_IDX_W-1:0] chkIdx_r;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         chkMask_r <= '0;
         chkAddr_r <= '0;
         chkLut_r  <= 1'b0;
         chkIdx_r  <= '0;
      end else begin
         chkMask_r <= lutMode ? subMask : selMask;
         chkAddr_r <= tlpAddr;
         chkLut_r  <= lutMode;
         chkIdx_r  <= lutIdx;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence missSeq;
      tlpValid && !anyHit;
   endsequence
   sequence dropSeq;
      dropValid_r && !fwdValid_r && !cfgValid_r;
   endsequence
   sequence cfgSeq;
      tlpValid && cfgHit;
   endsequence
   sequence cfgPulseSeq;
      cfgValid_r && !fwdValid_r ##1 (!cfgValid_r || $past(tlpValid));
   endsequence
   sequence dirHitSeq;
      tlpValid && anyHit && !cfgHit && !lutMode;
   endsequence
   sequence lutHitSeq;
      tlpValid && lutMode && lutOk;
   endsequence

   miss_dropped_a: assert property (missSeq |=> dropSeq)
      else $error("missed request was not dropped");
   offset_kept_a: assert property (
      fwdValid_r |-> ((fwdAddr_r ^ chkAddr_r) & chkMask_r) == 64'h0)
      else $error("offset changed by translation");
   lut_windows_a: assert property (
      fwdValid_r && chkLut_r |-> fwdWin_r == WIN_LUT_A
                              || fwdWin_r == WIN_LUT_B)
      else $error("table used by wrong window");
   win4_upper_a: assert property (
      fwdValid_r && chkLut_r && fwdWin_r == WIN_LUT_B
      |-> chkIdx_r >= LUT_SMALL && chkIdx_r < LUT_LARGE)
      else $error("window four left its table half");
   both_lut_a: assert property (
      tlpValid && bothLut && lutMode && hitIdx == WIN_LUT_A
      && lutIdx >= LUT_SMALL |=> dropValid_r && !fwdValid_r)
      else $error("window two exceeded small table");
   invalid_entry_a: assert property (
      tlpValid && lutMode && !lutRdValid |=> dropValid_r && !fwdValid_r)
      else $error("invalid entry used");
   cfg_local_a: assert property (cfgSeq |=> cfgPulseSeq)
      else $error("config access not flagged");
   wide_flag_a: assert property (
      fwdValid_r |-> fwdAddr64_r == (fwdAddr_r[ADDR_W-1:HALF_W] != 32'h0))
      else $error("address width flag wrong");
   idle_quiet_a: assert property (
      !tlpValid |=> !fwdValid_r && !dropValid_r && !cfgValid_r)
      else $error("output without request");

   // one outcome per request, routing taken from the hit source
   one_answer_a: assert property (
      tlpValid |=> $onehot({fwdValid_r, cfgValid_r, dropValid_r}))
      else $error("request without exactly one outcome");
   io_kept_a: assert property (
      tlpValid |=> fwdIo_r == $past(tlpIo))
      else $error("request type not carried");
   direct_route_a: assert property (
      dirHitSeq |=> fwdValid_r && fwdPart_r == $past(selPart)
                 && fwdWin_r == $past(hitIdx))
      else $error("direct hit not routed to window partition");
   lut_route_a: assert property (
      lutHitSeq |=> fwdValid_r && fwdPart_r == $past(lutRdPart))
      else $error("table hit not routed to entry partition");
   pair_odd_off_a: assert property (
      tlpValid && window_setup_reg[WIN_LUT_B][SU_PAIR] |-> !winHit[NUM_WIN-1])
      else $error("paired upper window matched on its own");
endmodule
`default_nettype wire

// [verification/bat_link_partner.sv]
// far-side request source feeding the translation block
`timescale 1ns/100ps
`default_nettype none
module bat_link_partner (
   // clock
   input  wire logic                       sys_clk,
   // request toward the bridge
   output var  logic                       tlpValid,
   output var  logic [bat_pkg::ADDR_W-1:0] tlpAddr,
   output var  logic                       tlpIo
);
   import bat_pkg::*;
   // ****************************************
   // request driver
   // ****************************************
   initial begin
      tlpValid = 1'b0;
      tlpAddr  = '0;
      tlpIo    = 1'b0;
   end
   // address and type qualify one request
   task automatic send(input logic [ADDR_W-1:0] addr, input logic io);
      @(negedge sys_clk);
      tlpValid = 1'b1;
      tlpAddr  = addr;
      tlpIo    = io;
      @(negedge sys_clk);
      tlpValid = 1'b0;
      // stale lines flip so a held value never passes
      tlpAddr  = ~addr;
      tlpIo    = ~io;
   endtask
endmodule
`default_nettype wire

// [verification/bat_bar_translation_tb_top.sv]
// self-checking bench for the window address translation block
`timescale 1ns/100ps
`default_nettype none
module bat_bar_translation_tb_top;
   import bat_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   localparam logic [2:0] FWD = 3'h4;
   localparam logic [2:0] CFG = 3'h2;
   localparam logic [2:0] DRP = 3'h1;
   logic                             sys_clk;
   logic                             resetn;
   logic                             tlpValid;
   logic [ADDR_W-1:0]                tlpAddr;
   logic                             tlpIo;
   logic [NUM_WIN-1:0][HALF_W-1:0]   barBase;
   logic [NUM_WIN-1:0][SETUP_W-1:0]  winSetup;
   logic [NUM_WIN-1:0][HALF_W-1:0]   lowTb;
   logic [NUM_WIN-1:0][HALF_W-1:0]   upTb;
   logic                             lutWrEn;
   logic [LUT_IDX_W-1:0]             lutWrIdx;
   logic                             lutWrValid;
   logic [PART_W-1:0]                lutWrPart;
   logic [ADDR_W-1:0]                lutWrAddr;
   logic                             fwdValid_r;
   logic [ADDR_W-1:0]                fwdAddr_r;
   logic                             fwdAddr64_r;
   logic [PART_W-1:0]                fwdPart_r;
   logic [WIN_W-1:0]                 fwdWin_r;
   logic                             fwdIo_r;
   logic                             cfgValid_r;
   logic                             dropValid_r;
   int                               mismatches = 0;
   int                               n_compared = 0;
   int                               cycles     = 0;

   bat_link_partner u_bat_link_partner (
      .sys_clk(sys_clk), .tlpValid(tlpValid), .tlpAddr(tlpAddr),
      .tlpIo(tlpIo));

   bat_bar_translation u_bat_bar_translation (
      .sys_clk(sys_clk), .resetn(resetn), .tlpValid(tlpValid),
      .tlpAddr(tlpAddr), .tlpIo(tlpIo), .barBase(barBase),
      .window_setup_reg(winSetup),
      .window_lower_translated_base(lowTb),
      .window_upper_translated_base(upTb),
      .lutWrEn(lutWrEn), .lutWrIdx(lutWrIdx), .lutWrValid(lutWrValid),
      .lutWrPart(lutWrPart), .lutWrAddr(lutWrAddr),
      .fwdValid_r(fwdValid_r), .fwdAddr_r(fwdAddr_r),
      .fwdAddr64_r(fwdAddr64_r), .fwdPart_r(fwdPart_r),
      .fwdWin_r(fwdWin_r), .fwdIo_r(fwdIo_r), .cfgValid_r(cfgValid_r),
      .dropValid_r(dropValid_r));
   // ****************************************
   // clock, timeout and tasks
   // ****************************************
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 1000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   function automatic logic [SETUP_W-1:0] mk(input int sz, input logic lk,
         input int pt, input logic io, input logic cf);
      logic [SETUP_W-1:0] s;
      s = '0;
      s[SU_EN] = 1'b1;
      s[SU_IO] = io;
      s[SU_LOOKUP] = lk;
      s[SU_CFG] = cf;
      s[SU_SIZE_L +: SIZE_W] = SIZE_W'(sz);
      s[SU_PART_L +: PART_W] = PART_W'(pt);
      return s;
   endfunction

   task automatic lutWrite(input int idx, input int pt,
         input logic [ADDR_W-1:0] a, input logic v);
      @(negedge sys_clk);
      lutWrEn    = 1'b1;
      lutWrIdx   = LUT_IDX_W'(idx);
      lutWrValid = v;
      lutWrPart  = PART_W'(pt);
      lutWrAddr  = a;
      @(negedge sys_clk);
      lutWrEn    = 1'b0;
   endtask

   // one request; answer is looked at in the cycle after it is taken
   task automatic check(input logic [ADDR_W-1:0] a, input logic io,
         input logic [2:0] kind, input logic [ADDR_W-1:0] ea,
         input logic [PART_W-1:0] ep, input logic [WIN_W-1:0] ew);
      u_bat_link_partner.send(a, io);
      n_compared++;
      if ({fwdValid_r, cfgValid_r, dropValid_r} !== kind) begin
         mismatches++;
         $display("unexpected at %0t: outcome for %h", $time, a);
      end
      n_compared++;
      if (kind != DRP && fwdAddr_r !== ea) begin
         mismatches++;
         $display("unexpected at %0t: address %h for %h", $time, fwdAddr_r, a);
      end
      n_compared++;
      if (kind == FWD && {fwdPart_r, fwdWin_r, fwdIo_r, fwdAddr64_r} !==
            {ep, ew, io, |ea[63:32]}) begin
         mismatches++;
         $display("unexpected at %0t: routing for %h", $time, a);
      end
   endtask

   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      resetn = 1'b0;
      lutWrEn = 1'b0;
      lutWrIdx = '0;
      lutWrValid = 1'b0;
      lutWrPart = '0;
      lutWrAddr = '0;
      barBase = '0;
      lowTb = '0;
      upTb = '0;
      winSetup = '0;
      winSetup[0] = mk(12, 1'b0, 0, 1'b0, 1'b1);
      barBase[1] = 32'hE1000000;
      winSetup[1] = mk(20, 1'b0, 0, 1'b0, 1'b0);
      lowTb[1] = 32'h10000000;
      barBase[2] = 32'hE0000000;
      winSetup[2] = mk(24, 1'b1, 0, 1'b0, 1'b0);
      winSetup[2][SU_LUT24] = 1'b1;
      barBase[3] = 32'hE1100000;
      winSetup[3] = mk(20, 1'b0, 2, 1'b0, 1'b0);
      lowTb[3] = 32'h18500000;
      upTb[3] = 32'h00000001;
      barBase[4] = 32'hE2000000;
      winSetup[4] = mk(24, 1'b1, 4, 1'b0, 1'b0);
      lowTb[4] = 32'h40000000;
      barBase[5] = 32'hE3000000;
      winSetup[5] = mk(20, 1'b0, 5, 1'b1, 1'b0);
      lowTb[5] = 32'h30000000;
      repeat (12) @(negedge sys_clk);
      resetn = 1'b1;
      lutWrite(0, 1, 64'h11000000, 1'b1);
      lutWrite(1, 2, 64'h18000000, 1'b1);
      lutWrite(3, 6, 64'h50000000, 1'b0);
      lutWrite(12, 3, 64'h20000000, 1'b1);
      check(64'h00000ABC, 1'b0, CFG, 64'hABC, 0, 0);
      check(64'hE1012345, 1'b0, FWD, 64'h10012345, 0, 1);
      check(64'hE1100010, 1'b0, FWD, 64'h118500010, 2, 3);
      check(64'hE0000010, 1'b0, FWD, 64'h11000010, 1, 2);
      check(64'hE01FFFFF, 1'b0, FWD, 64'h180FFFFF, 2, 2);
      check(64'hE0200000, 1'b0, DRP, '0, 0, 0);
      check(64'hE0300000, 1'b0, DRP, '0, 0, 0);
      check(64'hE0C00000, 1'b0, DRP, '0, 0, 0);
      check(64'hE2000005, 1'b0, FWD, 64'h20000005, 3, 4);
      check(64'hE4000000, 1'b0, DRP, '0, 0, 0);
      check(64'hE3000001, 1'b0, DRP, '0, 0, 0);
      check(64'hE3000001, 1'b1, FWD, 64'h30000001, 5, 5);
      check(64'h1E1000000, 1'b0, DRP, '0, 0, 0);
      // window four back to direct frees the large table for window two
      winSetup[4][SU_LOOKUP] = 1'b0;
      check(64'hE0600044, 1'b0, FWD, 64'h20000044, 3, 2);
      check(64'hE2000005, 1'b0, FWD, 64'h40000005, 4, 4);
      winSetup[4][SU_PAIR] = 1'b1;
      barBase[5] = 32'h00000002;
      check(64'h2E2000007, 1'b0, FWD, 64'h40000007, 4, 4);
      check(64'hE2000007, 1'b0, DRP, '0, 0, 0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
